// ==== rtl/itcu_timer.sv ====
// Purpose: 8-bit up-counting interval timer with two compare channels and overflow
// Assumes: Single clock clk_sys, 8-bit register port, read data one cycle after strobe
// Notes:   External count clock codes are not supported and stop the counter

`timescale 1ns/100ps
`default_nettype none

//Contract
// - Counter overflow sets the overflow flag in flag register bit 5.
// - Overflow flag clears only by reading it set, then writing zero.
// - Counter equal to compare A sets the match A flag, bit 6.
// - Counter equal to compare B sets the match B flag, bit 7.
// - Overflow raises an interrupt request only when control zero bit 5 is one.
// - Match A raises no request while control zero bit 6 is zero.
// - Match B raises no request while control zero bit 7 is zero.
// - Clear select bits 4:3 pick the clear condition; 00 never clears.
// - Clock code 011 with internal select one counts falling edges of clock/128.
// - Output select 3:2 set pin action on match B; 00 keeps the pin.
// - Output select 1:0 set pin action on match A; 00 keeps the pin.
// - Trigger edge bits 4:3 of control one pick the edge; 00 ignores trigger.
// - Trigger enable bit 2 gates counting; zero lets the pin not affect counting.
module itcu_timer (
  input  wire logic                          clk_sys,
  input  wire logic                          reset,
  input  wire logic [itcu_pkg::ADDR_W-1:0]   bus_addr,
  input  wire logic [itcu_pkg::DATA_W-1:0]   bus_wdata,
  input  wire logic                          bus_wr,
  input  wire logic                          bus_rd,
  output logic      [itcu_pkg::DATA_W-1:0]   bus_rdata,
  input  wire logic                          trigger_input_pin,
  output logic                               timer_output_pin,
  output logic                               irq
);
  import itcu_pkg::*;

  logic [7:0] ctrl0_r;
  logic [7:0] flags_r;
  logic [7:0] ctrl1_r;
  logic [7:0] cmp_a_r;
  logic [7:0] cmp_b_r;
  logic [7:0] count_r;
  logic [2:0] irq_stat_r;
  logic [2:0] irq_mask_r;
  logic [2:0] armed_r;
  logic [6:0] prescale_r;
  logic       trig_s1_r;
  logic       trig_s2_r;
  logic       trig_s3_r;
  logic       trig_run_r;
  logic       upd_r;
  logic [7:0] rdata_r;

  logic       wr_ctrl0;
  logic       wr_flags;
  logic       rd_flags;
  logic       wr_ctrl1;
  logic       wr_cmp_a;
  logic       wr_cmp_b;
  logic       wr_count;
  logic       wr_stat;
  logic       wr_mask;
  logic [1:0] clear_sel;
  logic [2:0] clock_sel;
  logic [1:0] edge_sel;
  logic       trig_en;
  logic [1:0] out_sel_a;
  logic [1:0] out_sel_b;
  logic [6:0] tap_mask;
  logic       prescale_hit;
  logic       count_gate;
  logic       tick;
  logic       trig_edge;
  logic       match_a;
  logic       match_b;
  logic       ovf_ev;
  logic       clr_now;
  logic [2:0] flag_ev;
  logic [2:0] flag_clr;
  logic [7:0] count_nxt;
  logic       pin_nxt;
  logic [7:0] rdata_nxt;

  // Prescaler bits that must all be one just before the selected divided clock falls
  function automatic logic [6:0] div_mask(input logic [2:0] cks, input logic icks);
    logic [6:0] m;
    m = 7'h00;
    unique case (cks)
      CKS_DIV_4_8:    m = icks ? 7'h07 : 7'h03;
      CKS_DIV_16_32:  m = icks ? 7'h1f : 7'h0f;
      CKS_DIV_64_128: m = icks ? 7'h7f : 7'h3f;
      default:        m = 7'h00;
    endcase
    return m;
  endfunction : div_mask

  function automatic logic out_apply(input logic cur, input logic hit, input logic [1:0] sel);
    logic v;
    v = cur;
    if (hit) begin
      unique case (sel)
        OUT_KEEP:   v = cur;
        OUT_LOW:    v = 1'b0;
        OUT_HIGH:   v = 1'b1;
        OUT_TOGGLE: v = ~cur;
      endcase
    end
    return v;
  endfunction : out_apply

  assign wr_ctrl0 = bus_wr && (bus_addr == ADDR_CTRL0);
  assign wr_flags = bus_wr && (bus_addr == ADDR_FLAGS);
  assign rd_flags = bus_rd && (bus_addr == ADDR_FLAGS);
  assign wr_ctrl1 = bus_wr && (bus_addr == ADDR_CTRL1);
  assign wr_cmp_a = bus_wr && (bus_addr == ADDR_CMP_A);
  assign wr_cmp_b = bus_wr && (bus_addr == ADDR_CMP_B);
  assign wr_count = bus_wr && (bus_addr == ADDR_COUNT);
  assign wr_stat  = bus_wr && (bus_addr == ADDR_IRQ_STAT);
  assign wr_mask  = bus_wr && (bus_addr == ADDR_IRQ_MASK);

  assign clear_sel = ctrl0_r[POS_CLEAR_SEL +: 2];
  assign clock_sel = ctrl0_r[POS_CLOCK_SEL +: 3];
  assign edge_sel  = ctrl1_r[POS_TRIG_EDGE +: 2];
  assign trig_en   = ctrl1_r[BIT_TRIG_EN];
  assign out_sel_a = flags_r[POS_OUT_SEL_A +: 2];
  assign out_sel_b = flags_r[POS_OUT_SEL_B +: 2];

  // Divider runs freely so that a clock change does not restart its phase
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      prescale_r <= PRESCALE_RST;
    end else begin
      prescale_r <= prescale_r + 7'h01;
    end
  end

  assign tap_mask     = div_mask(clock_sel, ctrl1_r[BIT_INT_CLK_SEL]);
  assign prescale_hit = (tap_mask != 7'h00) && ((prescale_r & tap_mask) == tap_mask);

  // Trigger pin crosses into clk_sys; edges are taken from the second and third stages
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      trig_s1_r <= 1'b0;
      trig_s2_r <= 1'b0;
      trig_s3_r <= 1'b0;
    end else begin
      trig_s1_r <= trigger_input_pin;
      trig_s2_r <= trig_s1_r;
      trig_s3_r <= trig_s2_r;
    end
  end

  always_comb begin
    trig_edge = 1'b0;
    unique case (edge_sel)
      EDGE_NONE: trig_edge = 1'b0;
      EDGE_RISE: trig_edge = trig_s2_r & ~trig_s3_r;
      EDGE_FALL: trig_edge = ~trig_s2_r & trig_s3_r;
      EDGE_BOTH: trig_edge = trig_s2_r ^ trig_s3_r;
    endcase
  end

  // With the trigger enabled, counting waits for the first selected edge
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      trig_run_r <= 1'b0;
    end else if (!trig_en) begin
      trig_run_r <= 1'b0;
    end else if (trig_edge) begin
      trig_run_r <= 1'b1;
    end
  end

  assign count_gate = !trig_en || trig_run_r;
  assign tick       = prescale_hit && count_gate;

  // Matches are judged once per counter update, so a parked count sets a flag only once
  assign match_a = upd_r && (count_r == cmp_a_r);
  assign match_b = upd_r && (count_r == cmp_b_r);

  always_comb begin
    clr_now = 1'b0;
    unique case (clear_sel)
      CLR_NONE:    clr_now = 1'b0;
      CLR_MATCH_A: clr_now = match_a;
      CLR_MATCH_B: clr_now = match_b;
      CLR_TRIGGER: clr_now = trig_edge;
    endcase
  end

  assign ovf_ev = tick && !clr_now && !wr_count && (count_r == COUNT_MAX);

  always_comb begin
    count_nxt = count_r;
    if (wr_count) begin
      count_nxt = bus_wdata;
    end else if (clr_now) begin
      count_nxt = COUNT_RST;
    end else if (tick) begin
      count_nxt = count_r + 8'h01;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      count_r <= COUNT_RST;
      upd_r   <= 1'b0;
    end else begin
      count_r <= count_nxt;
      upd_r   <= wr_count || clr_now || tick;
    end
  end

  // Flag order {match B, match A, overflow} follows bits 7:5
  assign flag_ev  = {match_b, match_a, ovf_ev};
  assign flag_clr = (wr_flags ? ~bus_wdata[POS_FLAGS +: 3] : 3'h0) & armed_r;

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      armed_r <= 3'h0;
    end else if (rd_flags) begin
      armed_r <= flags_r[POS_FLAGS +: 3];
    end else if (wr_flags) begin
      armed_r <= 3'h0;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      flags_r <= FLAGS_RST;
    end else begin
      flags_r[POS_FLAGS +: 3] <= flag_ev | (flags_r[POS_FLAGS +: 3] & ~flag_clr);
      if (wr_flags) begin
        flags_r[3:0] <= bus_wdata[3:0];
      end
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      ctrl0_r <= CTRL0_RST;
      ctrl1_r <= CTRL1_RST;
      cmp_a_r <= CMP_RST;
      cmp_b_r <= CMP_RST;
    end else begin
      if (wr_ctrl0) begin
        ctrl0_r <= bus_wdata;
      end
      if (wr_ctrl1) begin
        ctrl1_r <= bus_wdata & ~CTRL1_ONES;
      end
      if (wr_cmp_a) begin
        cmp_a_r <= bus_wdata;
      end
      if (wr_cmp_b) begin
        cmp_b_r <= bus_wdata;
      end
    end
  end

  // Match B is applied to the result of match A, so a set or clear on B wins when both hit together
  assign pin_nxt = out_apply(out_apply(timer_output_pin, match_a, out_sel_a), match_b, out_sel_b);

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      timer_output_pin <= 1'b0;
    end else begin
      timer_output_pin <= pin_nxt;
    end
  end

  // Requests latch only for enabled flags; the mask then gates the shared line
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      irq_stat_r <= 3'h0;
      irq_mask_r <= IRQ_MASK_RST;
    end else begin
      irq_stat_r <= (flag_ev & ctrl0_r[7:5]) | (irq_stat_r & ~(wr_stat ? bus_wdata[2:0] : 3'h0));
      if (wr_mask) begin
        irq_mask_r <= bus_wdata[2:0];
      end
    end
  end

  assign irq = |(irq_stat_r & irq_mask_r);

  always_comb begin
    rdata_nxt = 8'h00;
    unique case (bus_addr)
      ADDR_CTRL0:    rdata_nxt = ctrl0_r;
      ADDR_FLAGS:    rdata_nxt = flags_r | FLAGS_ONES;
      ADDR_CMP_A:    rdata_nxt = cmp_a_r;
      ADDR_CMP_B:    rdata_nxt = cmp_b_r;
      ADDR_COUNT:    rdata_nxt = count_r;
      ADDR_CTRL1:    rdata_nxt = ctrl1_r | CTRL1_ONES;
      ADDR_IRQ_STAT: rdata_nxt = {5'h00, irq_stat_r};
      ADDR_IRQ_MASK: rdata_nxt = {5'h00, irq_mask_r};
      default:       rdata_nxt = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      rdata_r <= 8'h00;
    end else if (bus_rd) begin
      rdata_r <= rdata_nxt;
    end else begin
      rdata_r <= 8'h00;
    end
  end

  assign bus_rdata = rdata_r;

  property p_ovf_set;
    @(posedge clk_sys) disable iff (reset)
      ovf_ev |=> flags_r[BIT_OVF_FLAG] && (count_r == COUNT_RST);
  endproperty
  a_ovf_set: assert property (p_ovf_set) else $error("overflow did not set flag or wrap");

  property p_ovf_needs_read;
    @(posedge clk_sys) disable iff (reset)
      (wr_flags && !armed_r[0] && flags_r[BIT_OVF_FLAG]) |=> flags_r[BIT_OVF_FLAG];
  endproperty
  a_ovf_needs_read: assert property (p_ovf_needs_read) else $error("overflow flag cleared without read");

  property p_ovf_read_clear;
    @(posedge clk_sys) disable iff (reset)
      (rd_flags && flags_r[BIT_OVF_FLAG] && !ovf_ev) ##1 !(wr_flags || rd_flags)
        ##1 (wr_flags && !bus_wdata[BIT_OVF_FLAG] && !ovf_ev)
        |=> !flags_r[BIT_OVF_FLAG];
  endproperty
  a_ovf_read_clear: assert property (p_ovf_read_clear) else $error("read then zero write did not clear");

  property p_match_a;
    @(posedge clk_sys) disable iff (reset)
      (upd_r && (count_r == cmp_a_r)) |=> flags_r[BIT_MATCH_FLAG_A];
  endproperty
  a_match_a: assert property (p_match_a) else $error("match A flag not set");

  property p_match_b;
    @(posedge clk_sys) disable iff (reset)
      (upd_r && (count_r == cmp_b_r)) |=> flags_r[BIT_MATCH_FLAG_B];
  endproperty
  a_match_b: assert property (p_match_b) else $error("match B flag not set");

  property p_irq_ovf;
    @(posedge clk_sys) disable iff (reset)
      (ovf_ev && ctrl0_r[BIT_OVF_IRQ_EN] && irq_mask_r[0]) |=> irq;
  endproperty
  a_irq_ovf: assert property (p_irq_ovf) else $error("enabled overflow raised no interrupt");

  property p_irq_a_off;
    @(posedge clk_sys) disable iff (reset)
      (!ctrl0_r[BIT_MATCH_IRQ_EN_A] && !irq_stat_r[1]) |=> !irq_stat_r[1];
  endproperty
  a_irq_a_off: assert property (p_irq_a_off) else $error("disabled match A raised request");

  property p_irq_b_off;
    @(posedge clk_sys) disable iff (reset)
      (!ctrl0_r[BIT_MATCH_IRQ_EN_B] && !irq_stat_r[2]) |=> !irq_stat_r[2];
  endproperty
  a_irq_b_off: assert property (p_irq_b_off) else $error("disabled match B raised request");

  property p_no_clear;
    @(posedge clk_sys) disable iff (reset)
      ((clear_sel == CLR_NONE) && !wr_count && !tick) |=> $stable(count_r);
  endproperty
  a_no_clear: assert property (p_no_clear) else $error("counter changed with clearing disabled");

  property p_div128;
    @(posedge clk_sys) disable iff (reset)
      (tick && (clock_sel == CKS_DIV_64_128) && ctrl1_r[BIT_INT_CLK_SEL]) |-> (prescale_r == 7'h7f);
  endproperty
  a_div128: assert property (p_div128) else $error("divide by 128 count off its edge");

  property p_pin_keep_b;
    @(posedge clk_sys) disable iff (reset)
      (match_b && !match_a && (out_sel_b == OUT_KEEP)) |=> $stable(timer_output_pin);
  endproperty
  a_pin_keep_b: assert property (p_pin_keep_b) else $error("pin moved on match B with keep");

  property p_pin_keep_a;
    @(posedge clk_sys) disable iff (reset)
      (match_a && !match_b && (out_sel_a == OUT_KEEP)) |=> $stable(timer_output_pin);
  endproperty
  a_pin_keep_a: assert property (p_pin_keep_a) else $error("pin moved on match A with keep");

  property p_trig_ignored;
    @(posedge clk_sys) disable iff (reset)
      ((edge_sel == EDGE_NONE) && !trig_run_r) |=> !trig_run_r;
  endproperty
  a_trig_ignored: assert property (p_trig_ignored) else $error("trigger acted with no edge selected");

  property p_trig_off;
    @(posedge clk_sys) disable iff (reset)
      (!trig_en && prescale_hit) |-> tick;
  endproperty
  a_trig_off: assert property (p_trig_off) else $error("trigger gated counting while disabled");

  property p_set_wins;
    @(posedge clk_sys) disable iff (reset)
      (ovf_ev && wr_flags && armed_r[0] && !bus_wdata[BIT_OVF_FLAG]) |=> flags_r[BIT_OVF_FLAG];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("clear beat a same-cycle overflow");

endmodule : itcu_timer

`default_nettype wire

// ==== rtl/itcu_pkg.sv ====
// Purpose: Constants shared by the interval timer compare unit
// Assumes: 8-bit register port with 16-bit byte addresses
// Notes:   Bit positions are given for the two control registers and the flag register

package itcu_pkg;

  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;

  localparam logic [15:0] ADDR_CTRL0    = 16'hffa0;
  localparam logic [15:0] ADDR_FLAGS    = 16'hffa1;
  localparam logic [15:0] ADDR_CMP_A    = 16'hffa2;
  localparam logic [15:0] ADDR_CMP_B    = 16'hffa3;
  localparam logic [15:0] ADDR_COUNT    = 16'hffa4;
  localparam logic [15:0] ADDR_CTRL1    = 16'hffa5;
  localparam logic [15:0] ADDR_IRQ_STAT = 16'hffa6;
  localparam logic [15:0] ADDR_IRQ_MASK = 16'hffa7;

  // timer_control_zero
  localparam int BIT_MATCH_IRQ_EN_B = 7;
  localparam int BIT_MATCH_IRQ_EN_A = 6;
  localparam int BIT_OVF_IRQ_EN     = 5;
  localparam int POS_CLEAR_SEL      = 3;
  localparam int POS_CLOCK_SEL      = 0;
  // timer_flags_and_output
  localparam int BIT_MATCH_FLAG_B   = 7;
  localparam int BIT_MATCH_FLAG_A   = 6;
  localparam int BIT_OVF_FLAG       = 5;
  localparam int POS_FLAGS          = 5;
  localparam int POS_OUT_SEL_B      = 2;
  localparam int POS_OUT_SEL_A      = 0;
  // timer_control_one
  localparam int POS_TRIG_EDGE      = 3;
  localparam int BIT_TRIG_EN        = 2;
  localparam int BIT_INT_CLK_SEL    = 0;

  localparam logic [7:0] CTRL0_RST      = 8'h00;
  localparam logic [7:0] FLAGS_RST      = 8'h00;
  localparam logic [7:0] FLAGS_ONES     = 8'h10;
  localparam logic [7:0] CTRL1_RST      = 8'h00;
  localparam logic [7:0] CTRL1_ONES     = 8'he2;
  localparam logic [7:0] CMP_RST        = 8'hff;
  localparam logic [7:0] COUNT_RST      = 8'h00;
  localparam logic [7:0] COUNT_MAX      = 8'hff;
  localparam logic [2:0] IRQ_MASK_RST   = 3'h7;
  localparam logic [6:0] PRESCALE_RST   = 7'h00;

  localparam logic [1:0] CLR_NONE    = 2'h0;
  localparam logic [1:0] CLR_MATCH_A = 2'h1;
  localparam logic [1:0] CLR_MATCH_B = 2'h2;
  localparam logic [1:0] CLR_TRIGGER = 2'h3;

  localparam logic [1:0] OUT_KEEP   = 2'h0;
  localparam logic [1:0] OUT_LOW    = 2'h1;
  localparam logic [1:0] OUT_HIGH   = 2'h2;
  localparam logic [1:0] OUT_TOGGLE = 2'h3;

  localparam logic [1:0] EDGE_NONE = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;

  localparam logic [2:0] CKS_DIV_4_8    = 3'h1;
  localparam logic [2:0] CKS_DIV_16_32  = 3'h2;
  localparam logic [2:0] CKS_DIV_64_128 = 3'h3;

endpackage : itcu_pkg

// ==== bench/itcu_timer_tb_top.sv ====
// Purpose: Self-checking bench for the interval timer compare unit
// Assumes: Register port with read data one cycle after the read strobe
// Notes:   Reset and register table first, then counting, flags, outputs and trigger

`timescale 1ns/100ps
`default_nettype none

`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin miscompares++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (got), (exp)); end end

module itcu_timer_tb_top;
  import itcu_pkg::*;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  rst;
    logic [7:0]  wd;
    logic [7:0]  rb;
  } itcu_row_t;

  // Reset read, write value, read-back after the write
  localparam itcu_row_t ROWS [9] = '{
    '{ADDR_CTRL0,    8'h00, 8'hf8, 8'hf8},
    '{ADDR_FLAGS,    8'h10, 8'h0f, 8'h1f},
    '{ADDR_CMP_A,    8'hff, 8'h10, 8'h10},
    '{ADDR_CMP_B,    8'hff, 8'h20, 8'h20},
    '{ADDR_COUNT,    8'h00, 8'h05, 8'h05},
    '{ADDR_CTRL1,    8'he2, 8'h19, 8'hfb},
    '{ADDR_IRQ_STAT, 8'h00, 8'h07, 8'h00},
    '{ADDR_IRQ_MASK, 8'h07, 8'h00, 8'h00},
    '{16'hffa8,      8'h00, 8'h55, 8'h00}
  };

  logic                clk_sys           = 1'b0;
  logic                reset             = 1'b1;
  logic [ADDR_W-1:0]   bus_addr          = '0;
  logic [DATA_W-1:0]   bus_wdata         = '0;
  logic                bus_wr            = 1'b0;
  logic                bus_rd            = 1'b0;
  logic [DATA_W-1:0]   bus_rdata;
  logic                trigger_input_pin = 1'b0;
  logic                timer_output_pin;
  logic                irq;
  logic [7:0]          rd_val;
  logic [7:0]          cnt0;
  int                  miscompares       = 0;
  int                  checks            = 0;

  always #2.5 clk_sys = ~clk_sys;

  itcu_timer DUT (
    .clk_sys           (clk_sys),
    .reset             (reset),
    .bus_addr          (bus_addr),
    .bus_wdata         (bus_wdata),
    .bus_wr            (bus_wr),
    .bus_rd            (bus_rd),
    .bus_rdata         (bus_rdata),
    .trigger_input_pin (trigger_input_pin),
    .timer_output_pin  (timer_output_pin),
    .irq               (irq)
  );

  task automatic stop_test();
    $display("miscompares=%0d checks=%0d", miscompares, checks);
    if (miscompares == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : stop_test

  task automatic reg_wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    bus_addr  <= a;
    bus_wdata <= d;
    bus_wr    <= 1'b1;
    @(posedge clk_sys);
    bus_wr    <= 1'b0;
  endtask : reg_wr

  // Data is sampled just after the edge that took the strobe, its only valid cycle
  task automatic reg_rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    bus_addr <= a;
    bus_rd   <= 1'b1;
    @(posedge clk_sys);
    bus_rd   <= 1'b0;
    #1;
    d = bus_rdata;
  endtask : reg_rd

  task automatic wait_irq(input int bound);
    int n;
    n = 0;
    while (irq !== 1'b1) begin
      @(posedge clk_sys);
      n++;
      if (n > bound) begin
        miscompares++;
        $display("CHECK FAILED t=%0t irq wait got=%h exp=%h", $time, irq, 1'b1);
        stop_test();
      end
    end
  endtask : wait_irq

  initial begin
    #1;
    `CHK(bus_rdata, 8'h00)
    `CHK(timer_output_pin, 1'b0)
    `CHK(irq, 1'b0)
    repeat (12) @(posedge clk_sys);
    reset <= 1'b0;
    foreach (ROWS[i]) begin
      reg_rd(ROWS[i].addr, rd_val);
      `CHK(rd_val, ROWS[i].rst)
      reg_wr(ROWS[i].addr, ROWS[i].wd);
      reg_rd(ROWS[i].addr, rd_val);
      `CHK(rd_val, ROWS[i].rb)
    end
    `CHK(irq, 1'b0)

    // Internal clock over 128, one step per 128 cycles, then wrap
    reg_wr(ADDR_IRQ_MASK, 8'h07);
    reg_wr(ADDR_CTRL1, 8'h01);
    reg_wr(ADDR_COUNT, 8'h80);
    reg_wr(ADDR_CTRL0, 8'h23);
    reg_rd(ADDR_COUNT, cnt0);
    repeat (126) @(posedge clk_sys);
    reg_rd(ADDR_COUNT, rd_val);
    `CHK(rd_val, cnt0 + 8'h01)
    reg_wr(ADDR_COUNT, 8'hfe);
    wait_irq(400);
    reg_wr(ADDR_CTRL0, 8'h20);
    reg_rd(ADDR_COUNT, rd_val);
    `CHK(rd_val, 8'h00)
    reg_rd(ADDR_IRQ_STAT, rd_val);
    `CHK(rd_val, 8'h01)

    // A zero write without a prior read must not clear the overflow flag
    reg_wr(ADDR_FLAGS, 8'h00);
    reg_rd(ADDR_FLAGS, rd_val);
    `CHK(rd_val, 8'h30)
    reg_wr(ADDR_FLAGS, 8'h00);
    reg_rd(ADDR_FLAGS, rd_val);
    `CHK(rd_val, 8'h10)
    reg_wr(ADDR_IRQ_STAT, 8'h01);
    #1;
    `CHK(irq, 1'b0)

    // Compare matches driving the output pin
    reg_wr(ADDR_CTRL0, 8'h80);
    reg_wr(ADDR_CMP_A, 8'h05);
    reg_wr(ADDR_CMP_B, 8'h07);
    reg_wr(ADDR_FLAGS, 8'h02);
    reg_wr(ADDR_COUNT, 8'h05);
    repeat (4) @(posedge clk_sys);
    #1;
    `CHK(timer_output_pin, 1'b1)
    reg_rd(ADDR_FLAGS, rd_val);
    `CHK(rd_val, 8'h52)
    reg_rd(ADDR_IRQ_STAT, rd_val);
    `CHK(rd_val, 8'h00)
    `CHK(irq, 1'b0)
    reg_wr(ADDR_FLAGS, 8'h04);
    reg_rd(ADDR_FLAGS, rd_val);
    `CHK(rd_val, 8'h14)
    reg_wr(ADDR_COUNT, 8'h05);
    repeat (4) @(posedge clk_sys);
    #1;
    `CHK(timer_output_pin, 1'b1)
    reg_wr(ADDR_COUNT, 8'h07);
    repeat (4) @(posedge clk_sys);
    #1;
    `CHK(timer_output_pin, 1'b0)
    `CHK(irq, 1'b1)
    reg_rd(ADDR_FLAGS, rd_val);
    `CHK(rd_val, 8'hd4)
    reg_rd(ADDR_IRQ_STAT, rd_val);
    `CHK(rd_val, 8'h04)
    reg_wr(ADDR_IRQ_STAT, 8'h07);

    // Clear on match A keeps the count at or below the compare value
    reg_wr(ADDR_CMP_A, 8'h02);
    reg_wr(ADDR_COUNT, 8'h00);
    reg_wr(ADDR_CTRL0, 8'h0b);
    repeat (900) @(posedge clk_sys);
    reg_rd(ADDR_COUNT, rd_val);
    `CHK(rd_val <= 8'h02, 1'b1)

    // Trigger gate holds the count until a rising edge on the pin
    // Gate first, so no free-running tick can move the count before it closes
    reg_wr(ADDR_CTRL1, 8'h0d);
    reg_wr(ADDR_CTRL0, 8'h03);
    reg_wr(ADDR_COUNT, 8'h40);
    repeat (300) @(posedge clk_sys);
    reg_rd(ADDR_COUNT, rd_val);
    `CHK(rd_val, 8'h40)
    trigger_input_pin <= 1'b1;
    repeat (300) @(posedge clk_sys);
    reg_rd(ADDR_COUNT, rd_val);
    `CHK(rd_val == 8'h40, 1'b0)
    stop_test();
  end

endmodule : itcu_timer_tb_top

`default_nettype wire
